// ---- inc/mmwd_pkg.sv ----
/*
  constants and carrier types for the memory map and wait-state decoder.
  assumes a 22-bit word address from the processor memory bus, one system clock.
*/
package mmwd_pkg;
  localparam int unsigned ADDR_W = 22;
  localparam int unsigned WS_W   = 5;

  localparam logic [ADDR_W-1:0] M01_LO   = 22'h000000;
  localparam logic [ADDR_W-1:0] M01_HI   = 22'h0007ff;
  localparam logic [ADDR_W-1:0] PF0_LO   = 22'h000800;
  localparam logic [ADDR_W-1:0] PF0_HI   = 22'h000fff;
  localparam logic [ADDR_W-1:0] PF1_LO   = 22'h006000;
  localparam logic [ADDR_W-1:0] PF1_HI   = 22'h006fff;
  localparam logic [ADDR_W-1:0] CAN_HI   = 22'h0067ff;
  localparam logic [ADDR_W-1:0] PF2_LO   = 22'h007000;
  localparam logic [ADDR_W-1:0] PF2_HI   = 22'h007fff;
  localparam logic [ADDR_W-1:0] L01_LO   = 22'h008000;
  localparam logic [ADDR_W-1:0] L01_HI   = 22'h009fff;
  localparam logic [ADDR_W-1:0] OTP_LO   = 22'h3d7800;
  localparam logic [ADDR_W-1:0] OTP_HI   = 22'h3d7bff;
  localparam logic [ADDR_W-1:0] OTP_RSV  = 22'h3d7bfc;
  localparam logic [ADDR_W-1:0] FL32_LO  = 22'h3f0000;
  localparam logic [ADDR_W-1:0] FL16_LO  = 22'h3f4000;
  localparam logic [ADDR_W-1:0] FL_HI    = 22'h3f7fff;
  localparam logic [ADDR_W-1:0] TAIL_LO  = 22'h3f7f80;
  localparam logic [ADDR_W-1:0] DATA_LO  = 22'h3f7ff0;
  localparam logic [ADDR_W-1:0] DATA_HI  = 22'h3f7ff5;
  localparam logic [ADDR_W-1:0] BOOT_LO  = 22'h3f7ff6;
  localparam logic [ADDR_W-1:0] BOOT_HI  = 22'h3f7ff7;
  localparam logic [ADDR_W-1:0] PWD_LO   = 22'h3f7ff8;
  localparam logic [ADDR_W-1:0] BROM_LO  = 22'h3ff000;
  localparam logic [ADDR_W-1:0] BROM_HI  = 22'h3fffff;

  localparam int unsigned SEC32_SHIFT = 13;
  localparam int unsigned SEC16_SHIFT = 12;

  localparam logic [WS_W-1:0] WS_ZERO    = 5'h00;
  localparam logic [WS_W-1:0] WS_ONE     = 5'h01;
  localparam logic [WS_W-1:0] WS_PF_READ = 5'h02;
  localparam logic [WS_W-1:0] WS_PWD     = 5'h10;
  localparam logic [WS_W-1:0] WS_BROM    = 5'h01;
  localparam logic [WS_W-1:0] WS_OTP_MIN = 5'h01;

  typedef enum logic [8:0] {
    RG_NONE  = 9'h001,
    RG_M01   = 9'h002,
    RG_PF0   = 9'h004,
    RG_PF1   = 9'h008,
    RG_PF2   = 9'h010,
    RG_L01   = 9'h020,
    RG_OTP   = 9'h040,
    RG_FLASH = 9'h080,
    RG_BROM  = 9'h100
  } mmwd_region_t;

  typedef enum logic [2:0] {
    BUS_DIRECT = 3'h1,
    BUS_P32    = 3'h2,
    BUS_P16    = 3'h4
  } mmwd_bus_t;

  // sector code: 0 = d (lowest) .. 3 = a (highest)
  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
  } mmwd_req_t;

  typedef struct packed {
    mmwd_region_t region;
    mmwd_bus_t    bus;
    logic         sector_hit;
    logic [1:0]   sector;
    logic         boot_entry;
    logic         password;
    logic         data_only;
    logic         reserved;
  } mmwd_info_t;
endpackage

// ---- rtl/mmwd_wait_ctr.sv ----
/*
  down-counter for wait-states of one access, plus a stretch hold.
  assumes i_load only while idle; i_hold comes from a peripheral that stretches.
*/
module mmwd_wait_ctr #(
  parameter int unsigned W = 5
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_count,
  input  wire logic         i_hold,
  output logic              o_busy,
  output logic              o_done
);
  logic [W-1:0] cnt_r;
  logic         busy_r;
  wire          at_zero = (cnt_r == '0);

  assign o_busy = busy_r;
  assign o_done = busy_r & at_zero & ~i_hold;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
    end else if (i_load) begin
      cnt_r  <= i_count;
      busy_r <= 1'b1;
    end else if (busy_r && !at_zero) begin
      cnt_r <= cnt_r - 1'b1;
    end else if (o_done) begin
      busy_r <= 1'b0;
    end
  end
endmodule

// ---- rtl/mmwd_decoder.sv ----
/*
  memory map decoder with per-area wait-states and write-then-read ordering
  for the grouped peripheral frames one and two.
  assumes the processor holds i_req/i_acc until o_ready, and that wait-state
  settings from the flash control block are stable during an access.
  a stretch from the mailbox can peripheral holds completion as long as it lasts.
*/
module mmwd_decoder #(
  parameter bit FLASH_32K = 1'b1
) (
  input  wire logic                            i_mclk,
  input  wire logic                            i_rst,
  input  wire logic                            i_req,
  input  wire mmwd_pkg::mmwd_req_t             i_acc,
  input  wire logic                            i_rom_part,
  input  wire logic                            i_protect_en,
  input  wire logic [mmwd_pkg::WS_W-1:0]       i_flash_ws,
  input  wire logic [mmwd_pkg::WS_W-1:0]       i_otp_ws,
  input  wire logic                            i_can_wait,
  input  wire logic                            i_boot_flash,
  output logic                                 o_ready,
  output logic                                 o_done,
  output mmwd_pkg::mmwd_info_t                 o_info,
  output logic [mmwd_pkg::ADDR_W-1:0]          o_boot_vector
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_BUSY = 2'h2
  } mmwd_state_t;

  function automatic logic in_rng(input logic [mmwd_pkg::ADDR_W-1:0] a,
                                  input logic [mmwd_pkg::ADDR_W-1:0] lo,
                                  input logic [mmwd_pkg::ADDR_W-1:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  // widen a one-cycle penalty to the wait-state width
  function automatic logic [mmwd_pkg::WS_W-1:0] ws_ext(input logic pen);
    ws_ext = {{(mmwd_pkg::WS_W-1){1'b0}}, pen};
  endfunction

  mmwd_state_t          state_r;
  mmwd_state_t          state_nxt;
  mmwd_pkg::mmwd_info_t info_r;
  logic                 can_acc_r;
  logic                 last_wr_prot_r;
  logic                 last_wr_pf1_r;
  logic                 just_done_r;
  logic [mmwd_pkg::ADDR_W-1:0] last_addr_r;

  wire [mmwd_pkg::ADDR_W-1:0] a = i_acc.addr;
  wire take = i_req && (state_r == ST_IDLE);

  // address decode
  wire hit_m01  = in_rng(a, mmwd_pkg::M01_LO, mmwd_pkg::M01_HI);
  wire hit_pf0  = in_rng(a, mmwd_pkg::PF0_LO, mmwd_pkg::PF0_HI);
  wire hit_pf1  = in_rng(a, mmwd_pkg::PF1_LO, mmwd_pkg::PF1_HI);
  wire hit_pf2  = in_rng(a, mmwd_pkg::PF2_LO, mmwd_pkg::PF2_HI);
  wire hit_l01  = in_rng(a, mmwd_pkg::L01_LO, mmwd_pkg::L01_HI);
  wire hit_otp  = in_rng(a, mmwd_pkg::OTP_LO, mmwd_pkg::OTP_HI);
  wire hit_brom = in_rng(a, mmwd_pkg::BROM_LO, mmwd_pkg::BROM_HI);
  wire [mmwd_pkg::ADDR_W-1:0] fl_lo = FLASH_32K ? mmwd_pkg::FL32_LO : mmwd_pkg::FL16_LO;
  wire hit_flash = in_rng(a, fl_lo, mmwd_pkg::FL_HI);
  wire hit_sec   = in_rng(a, fl_lo, mmwd_pkg::TAIL_LO - 1'b1);
  wire hit_boot  = in_rng(a, mmwd_pkg::BOOT_LO, mmwd_pkg::BOOT_HI);
  wire hit_pwd   = in_rng(a, mmwd_pkg::PWD_LO, mmwd_pkg::FL_HI);
  wire hit_dat   = in_rng(a, mmwd_pkg::DATA_LO, mmwd_pkg::DATA_HI);
  // a rom part only flags its reserved words; they are still served
  wire hit_otp_rsv = in_rng(a, mmwd_pkg::OTP_RSV, mmwd_pkg::OTP_HI);
  wire hit_rsv   = i_rom_part && (hit_dat || hit_otp_rsv);
  // only the mailbox can part of frame one may stretch an access
  wire hit_can   = in_rng(a, mmwd_pkg::PF1_LO, mmwd_pkg::CAN_HI);
  wire hit_prot  = (hit_pf1 || hit_pf2) && i_protect_en;

  // sector: 0 = d at the base, 3 = a just below the reserved tail
  wire [mmwd_pkg::ADDR_W-1:0] fl_off = a - fl_lo;
  wire [1:0] sec32 = fl_off[mmwd_pkg::SEC32_SHIFT+1:mmwd_pkg::SEC32_SHIFT];
  wire [1:0] sec16 = fl_off[mmwd_pkg::SEC16_SHIFT+1:mmwd_pkg::SEC16_SHIFT];
  wire [1:0] sec_raw = FLASH_32K ? sec32 : sec16;
  // the reserved tail and other areas read as sector 0 with no hit
  wire [1:0] sector  = hit_sec ? sec_raw : 2'h0;

  mmwd_pkg::mmwd_region_t region;
  mmwd_pkg::mmwd_bus_t    bus;
  assign region = hit_m01   ? mmwd_pkg::RG_M01 :
                  hit_pf0   ? mmwd_pkg::RG_PF0 :
                  hit_pf1   ? mmwd_pkg::RG_PF1 :
                  hit_pf2   ? mmwd_pkg::RG_PF2 :
                  hit_l01   ? mmwd_pkg::RG_L01 :
                  hit_otp   ? mmwd_pkg::RG_OTP :
                  hit_flash ? mmwd_pkg::RG_FLASH :
                  hit_brom  ? mmwd_pkg::RG_BROM : mmwd_pkg::RG_NONE;
  assign bus = hit_pf1 ? mmwd_pkg::BUS_P32 :
               hit_pf2 ? mmwd_pkg::BUS_P16 :
               mmwd_pkg::BUS_DIRECT;

  // base wait-states per area
  // otp below its floor is raised, not refused
  wire [mmwd_pkg::WS_W-1:0] otp_ws =
    (i_otp_ws < mmwd_pkg::WS_OTP_MIN) ? mmwd_pkg::WS_OTP_MIN : i_otp_ws;
  wire [mmwd_pkg::WS_W-1:0] pf_ws = i_acc.we ? mmwd_pkg::WS_ZERO
                                             : mmwd_pkg::WS_PF_READ;
  wire [mmwd_pkg::WS_W-1:0] base_ws =
    (hit_pf1 || hit_pf2) ? pf_ws :
    hit_otp              ? otp_ws :
    hit_pwd              ? mmwd_pkg::WS_PWD :
    hit_flash            ? i_flash_ws :
    hit_brom             ? mmwd_pkg::WS_BROM :
    mmwd_pkg::WS_ZERO;

  // protected read behind a protected write to another word waits one cycle for the write
  wire order_pen = hit_prot && !i_acc.we && last_wr_prot_r
                   && (a != last_addr_r);
  // frame one write following a frame one write with no idle cycle between them
  wire b2b_pen = hit_pf1 && i_acc.we && last_wr_pf1_r && just_done_r;
  wire [mmwd_pkg::WS_W-1:0] order_ws = ws_ext(order_pen);
  wire [mmwd_pkg::WS_W-1:0] b2b_ws   = ws_ext(b2b_pen);
  // penalties only reach frame areas, whose base is at most two: no overflow
  wire [mmwd_pkg::WS_W-1:0] total_ws = base_ws + order_ws + b2b_ws;

  wire busy;
  wire done;
  // a can stretch holds completion once the count has run out
  mmwd_wait_ctr #(
    .W (mmwd_pkg::WS_W)
  ) u_wait (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_load  (take),
    .i_count (total_ws),
    .i_hold  (can_acc_r && i_can_wait),
    .o_busy  (busy),
    .o_done  (done)
  );

  mmwd_pkg::mmwd_info_t info_nxt;
  assign info_nxt = '{region:     region,
                      bus:        bus,
                      sector_hit: hit_sec,
                      sector:     sector,
                      boot_entry: hit_boot,
                      password:   hit_pwd,
                      data_only:  hit_dat,
                      reserved:   hit_rsv};

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (take) begin
          state_nxt = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (done) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  // ready returns the edge after done, so a chained take lands one cycle later
  assign o_ready = (state_r == ST_IDLE);
  assign o_done  = done && busy;
  assign o_info  = info_r;
  // fetch address: flash entry when starting from flash, else the last boot rom word
  assign o_boot_vector = i_boot_flash ? mmwd_pkg::BOOT_LO : mmwd_pkg::BROM_HI;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // o_info stands from one take to the next
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      info_r <= '{region: mmwd_pkg::RG_NONE, bus: mmwd_pkg::BUS_DIRECT, default: '0};
    end else if (take) begin
      info_r <= info_nxt;
    end
  end

  // history of the previous access for ordering and back-to-back penalties
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      just_done_r <= 1'b0;
    end else begin
      just_done_r <= done;
    end
  end

  // the stretch input only counts for can accesses
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      can_acc_r <= 1'b0;
    end else if (take) begin
      can_acc_r <= hit_can;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      last_wr_prot_r <= 1'b0;
      last_addr_r    <= '0;
    end else if (take) begin
      last_wr_prot_r <= hit_prot && i_acc.we;
      last_addr_r    <= a;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      last_wr_pf1_r <= 1'b0;
    end else if (take) begin
      last_wr_pf1_r <= hit_pf1 && i_acc.we;
    end
  end
endmodule

// ---- sim/mmwd_decoder_sva.sv ----
/*
  port checker for mmwd_decoder: wait-state counts, bus attach, sectors.
  assumes bind onto every decoder instance, one clock, sync reset.
*/
module mmwd_decoder_sva #(
  parameter bit FLASH_32K = 1'b1
) (
  input wire logic                 i_mclk,
  input wire logic                 i_rst,
  input wire logic                 i_req,
  input wire mmwd_pkg::mmwd_req_t  i_acc,
  input wire logic                 i_protect_en,
  input wire logic [4:0]           i_flash_ws,
  input wire logic [4:0]           i_otp_ws,
  input wire logic                 i_boot_flash,
  input wire logic                 o_ready,
  input wire logic                 o_done,
  input wire mmwd_pkg::mmwd_info_t o_info,
  input wire logic [21:0]          o_boot_vector
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  wire       tk = i_req && o_ready;
  wire [8:0] rg = o_info.region;
  wire [21:0] a = i_acc.addr;
  // region is read back from o_info, so a missed decode leaves these checks vacuous
  property p_zero; tk |=> (rg inside {9'h002, 9'h004, 9'h020}) |-> o_done; endproperty
  a_zero: assert property (p_zero) else $error("zero-wait area late");
  property p_brom; tk |=> (rg == 9'h100) |-> !o_done ##1 o_done; endproperty
  a_brom: assert property (p_brom) else $error("boot rom wait wrong");
  property p_pfrd; tk && !i_acc.we && !i_protect_en |=> (rg == 9'h010) |-> !o_done[*2] ##1 o_done;
  endproperty
  a_pfrd: assert property (p_pfrd) else $error("frame read wait wrong");
  property p_pf0; tk |=> (rg == 9'h004) |-> (o_info.bus == mmwd_pkg::BUS_DIRECT); endproperty
  a_pf0: assert property (p_pf0) else $error("frame zero bus wrong");
  property p_b32; tk |=> (rg == 9'h008) |-> (o_info.bus == mmwd_pkg::BUS_P32); endproperty
  a_b32: assert property (p_b32) else $error("frame one bus wrong");
  property p_pwd; tk && a inside {[22'h3f7ff8:22'h3f7fff]} |=>
    (!o_done)[*8] ##1 (!o_done)[*8] ##1 o_done;
  endproperty
  a_pwd: assert property (p_pwd) else $error("password wait wrong");
  property p_fl0; tk && i_flash_ws == 5'h00 |=> (rg == 9'h080 && !o_info.password) |-> o_done;
  endproperty
  a_fl0: assert property (p_fl0) else $error("flash zero wait late");
  property p_otp; tk && i_otp_ws == 5'h00 |=> (rg == 9'h040) |-> !o_done ##1 o_done; endproperty
  a_otp: assert property (p_otp) else $error("otp floor wrong");
  property p_boot; o_boot_vector == (i_boot_flash ? 22'h3f7ff6 : 22'h3fffff); endproperty
  a_boot: assert property (p_boot) else $error("boot vector wrong");
  property p_sec;
    tk && a >= (FLASH_32K ? 22'h3f0000 : 22'h3f4000) && a < 22'h3f7f80 |=> o_info.sector_hit &&
      o_info.sector == (FLASH_32K ? $past(a[14:13]) : $past(a[13:12]));
  endproperty
  a_sec: assert property (p_sec) else $error("sector decode wrong");
  c_pfrd: cover property (tk && !i_acc.we && a[21:12] == 10'h006);
  c_pwd: cover property (tk && a inside {[22'h3f7ff8:22'h3f7fff]});
  c_b2b: cover property (o_done ##1 (tk && i_acc.we));
endmodule
bind mmwd_decoder mmwd_decoder_sva #(.FLASH_32K(FLASH_32K)) sva_u (.i_mclk, .i_rst, .i_req,
  .i_acc, .i_protect_en, .i_flash_ws, .i_otp_ws, .i_boot_flash, .o_ready, .o_done, .o_info,
  .o_boot_vector);

// ---- sim/mmwd_can_model.sv ----
/*
  mailbox can peripheral model: stretches a taken can access.
  assumes i_take marks the edge an access is taken.
*/
module mmwd_can_model (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_take,
  input  wire logic       i_can_sel,
  input  wire logic [3:0] i_stretch,
  output logic            o_can_wait
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;
  // reloaded per can take, so each can access gets its own stretch
  always_ff @(posedge i_mclk) begin
    if (i_rst) cnt_r <= 4'h0;
    else if (i_take && i_can_sel) cnt_r <= i_stretch;
    else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
  end
  assign o_can_wait = (cnt_r != 4'h0);
endmodule

// ---- sim/testbench.sv ----
/*
  self-checking bench for mmwd_decoder, 32k and 16k maps side by side.
  assumes 40 MHz clock; inputs driven at the falling edge.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 i_mclk, i_rst, i_req, i_rom_part, i_protect_en, i_boot_flash;
  logic                 can_wait, o_ready, o_done, r16;
  logic [4:0]           i_flash_ws, i_otp_ws;
  logic [3:0]           stretch;
  logic [21:0]          o_boot_vector;
  mmwd_pkg::mmwd_req_t  i_acc;
  mmwd_pkg::mmwd_info_t o_info, info16;
  int                   fails = 0, cmp_count = 0, cyc = 0;
  mmwd_decoder #(.FLASH_32K(1'b1)) dut_u (.i_mclk, .i_rst, .i_req, .i_acc, .i_rom_part,
    .i_protect_en, .i_flash_ws, .i_otp_ws, .i_can_wait(can_wait), .i_boot_flash, .o_ready,
    .o_done, .o_info, .o_boot_vector);
  mmwd_decoder #(.FLASH_32K(1'b0)) dut16_u (.i_mclk, .i_rst, .i_req, .i_acc, .i_rom_part,
    .i_protect_en, .i_flash_ws, .i_otp_ws, .i_can_wait(can_wait), .i_boot_flash,
    .o_ready(r16), .o_done(), .o_info(info16), .o_boot_vector());
  mmwd_can_model can_u (.i_mclk, .i_rst, .i_take(i_req && o_ready),
    .i_can_sel(i_acc.addr inside {[22'h006000:22'h0067ff]}), .i_stretch(stretch),
    .o_can_wait(can_wait));
  task automatic end_sim;
    if (fails == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // request stays up while busy; unchained, it drops in the done cycle and
  // one idle cycle passes, so no back-to-back penalty applies
  task automatic acc(input logic we, input logic [21:0] a, input logic [31:0] exp,
                     input bit b2b = 1'b0);
    logic [31:0] lat;
    i_acc.we = we;
    i_acc.addr = a;
    i_req = 1'b1;
    while (o_ready !== 1'b1) @(negedge i_mclk);
    @(negedge i_mclk);
    lat = 1;
    while (o_done !== 1'b1 && lat < 40) begin
      @(negedge i_mclk);
      lat++;
    end
    chk("latency", lat, exp);
    if (!b2b) begin
      i_req = 1'b0;
      @(negedge i_mclk);
      @(negedge i_mclk);
    end
  endtask
  task automatic t_fixed;
    acc(0, 22'h000100, 1);
    chk("region", o_info.region, mmwd_pkg::RG_M01);
    acc(1, 22'h000900, 1);
    chk("bus", o_info.bus, mmwd_pkg::BUS_DIRECT);
    acc(0, 22'h009000, 1);
    acc(0, 22'h3ff000, 2);
    chk("region", o_info.region, mmwd_pkg::RG_BROM);
    acc(0, 22'h006800, 3);
    chk("bus", o_info.bus, mmwd_pkg::BUS_P32);
    acc(0, 22'h007100, 3);
    chk("bus", o_info.bus, mmwd_pkg::BUS_P16);
    acc(1, 22'h007100, 1);
  endtask
  task automatic t_order;
    acc(1, 22'h006800, 1);
    acc(0, 22'h006804, 4);
    acc(1, 22'h006800, 1);
    acc(0, 22'h006800, 3);
    i_protect_en = 1'b0;
    acc(1, 22'h007000, 1);
    acc(0, 22'h007004, 3);
    i_protect_en = 1'b1;
    acc(1, 22'h006800, 1, 1);
    acc(1, 22'h006804, 2);
    acc(1, 22'h006808, 1);
    acc(1, 22'h007000, 1, 1);
    acc(1, 22'h007004, 1);
    stretch = 4'h3;
    acc(1, 22'h006000, 4);
    stretch = 4'h0;
  endtask
  task automatic sec(input logic [21:0] a, input logic [2:0] e32, input logic [2:0] e16);
    acc(0, a, 1);
    chk("sec32", {o_info.sector_hit, o_info.sector}, e32);
    chk("sec16", {info16.sector_hit, info16.sector}, e16);
    chk("rdy16", r16, 1);
  endtask
  task automatic t_sector;
    sec(22'h3f0000, 3'h4, 3'h0);
    sec(22'h3f2000, 3'h5, 3'h0);
    sec(22'h3f4000, 3'h6, 3'h4);
    sec(22'h3f5000, 3'h6, 3'h5);
    sec(22'h3f7f7f, 3'h7, 3'h7);
    sec(22'h3f7f80, 3'h0, 3'h0);
  endtask
  task automatic t_flash;
    i_flash_ws = 5'h03;
    acc(0, 22'h3f5000, 4);
    acc(0, 22'h3f7ff8, 17);
    chk("pwd", o_info.password, 1);
    acc(0, 22'h3f7ff6, 4);
    chk("boot", o_info.boot_entry, 1);
    acc(0, 22'h3f7ff0, 4);
    chk("data", o_info.data_only, 1);
    i_otp_ws = 5'h00;
    acc(0, 22'h3d7800, 2);
    i_otp_ws = 5'h04;
    acc(0, 22'h3d7900, 5);
    i_rom_part = 1'b1;
    acc(0, 22'h3d7bfc, 5);
    chk("rsv", o_info.reserved, 1);
    acc(0, 22'h3f7ff5, 4);
    chk("rsv", o_info.reserved, 1);
    i_rom_part = 1'b0;
    acc(0, 22'h3d7bff, 5);
    chk("rsv", o_info.reserved, 0);
    chk("vec", o_boot_vector, 22'h3fffff);
    i_boot_flash = 1'b1;
    @(negedge i_mclk);
    chk("vec", o_boot_vector, 22'h3f7ff6);
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      end_sim;
    end
  end
  initial begin
    {i_rst, i_req, i_acc, i_rom_part, i_protect_en, i_boot_flash} = {2'h2, 23'h0, 3'h2};
    i_flash_ws = 5'h00;
    i_otp_ws = 5'h01;
    stretch = 4'h0;
    repeat (6) @(negedge i_mclk);
    chk("rst_ready", o_ready, 1);
    chk("rst_region", o_info.region, mmwd_pkg::RG_NONE);
    i_rst = 1'b0;
    t_fixed;
    t_order;
    t_sector;
    t_flash;
    end_sim;
  end
endmodule
